// File: rtl/i2cs_defs.svh
/*
 * Constants of the i2c slave addressing and acknowledge block: mode codes,
 * address patterns, bit counts and reset values.
 * Assumes it is included by bare name from rtl/ after the package.
 */
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// ****************************************
// port mode codes
// ****************************************
`define I2CS_MODE_7B      4'h6
`define I2CS_MODE_10B     4'h7
`define I2CS_MODE_7B_SP   4'hE
`define I2CS_MODE_10B_SP  4'hF
`define I2CS_MODE_TEN_BIT 0
`define I2CS_MODE_SP_BIT  3

// ****************************************
// address layout and byte timing
// ****************************************
`define I2CS_TEN_PREFIX   5'h1E
`define I2CS_ADDR_RST     8'h00
`define I2CS_RW_MASK      8'hFE
`define I2CS_ACK_CNT      4'h8
`define I2CS_END_CNT      4'h9
`define I2CS_BUF_DEPTH    2

`endif

// File: rtl/i2cs_pkg.sv
/*
 * Types of the i2c slave addressing and acknowledge block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2cs_pkg;

	typedef enum logic [4:0]
	{
		ST_IDLE    = 5'h01,
		ST_ADDR    = 5'h02,
		ST_ADDR_LO = 5'h04,
		ST_DATA    = 5'h08,
		ST_READ    = 5'h10
	} i2cs_state_t;

	typedef struct packed
	{
		logic       is_addr;
		logic [7:0] data;
	} i2cs_rx_t;

endpackage

// File: rtl/i2cs_buf.sv
/*
 * Small shift buffer with valid and ready on both sides.
 * Assumes a single clock domain; the head entry feeds the reader directly.
 */
`timescale 1ns/1ps
`default_nettype none

module i2cs_buf
#(
	parameter int W     = 9,
	parameter int DEPTH = 2
)
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  ent_ff [DEPTH];
	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	logic          full_ff;
	logic          valid_ff;
	logic          push;
	logic          pop;

	assign push      = in_valid & ~full_ff;
	assign pop       = valid_ff & out_ready;
	assign in_ready  = ~full_ff;
	assign out_valid = valid_ff;
	assign out_data  = ent_ff[0];
	assign nxt_count = count_ff + CW'(push) - CW'(pop);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_ff <= '0;
			full_ff  <= 1'b0;
			valid_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			full_ff  <= (nxt_count == CW'(DEPTH));
			valid_ff <= (nxt_count != '0);
		end
	end

	// entries shift toward the head on each pop
	genvar i;
	for (i = 0; i < DEPTH; i++)
	begin : g_ent
		localparam int NXT = (i == DEPTH - 1) ? i : i + 1;
		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
				ent_ff[i] <= '0;
			else if (pop && push && count_ff == CW'(i + 1))
				ent_ff[i] <= in_data;
			else if (pop)
				ent_ff[i] <= ent_ff[NXT];
			else if (push && count_ff == CW'(i))
				ent_ff[i] <= in_data;
		end
	end

endmodule

`default_nettype wire

// File: rtl/i2cs_slave.sv
/*
 * I2C slave address match and acknowledge engine with 7-bit and 10-bit
 * addressing, software or automatic acknowledge, and clock stretching.
 * Assumes scl and sda arrive asynchronously and are open drain outside;
 * control and status bits are plain ports on the clk domain.
 */
// Notes on behaviour
// - ninth clock is the acknowledge; receiver pulls sda low, transmitter releases
// - bus level at the ninth rising edge is kept as ack status
// - with hold enables set, software's acknowledge value is driven
// - with both hold enables clear, acknowledge is generated automatically
// - byte arriving with buffer full or overflow set is not acknowledged
// - when addressed, ack time flag sets after eighth falling scl edge
// - ack time flag works only when a hold enable is set
// - mode select chooses 7-bit or 10-bit, with or without start/stop interrupts
// - start/stop interrupt modes flag start, restart and stop
// - first byte after start or restart is compared with slave address
// - address match loads buffer and raises interrupt
// - 7-bit or 10-bit high byte address mismatch goes idle silently
// - masked address bits are ignored in the compare
// - 7-bit compare ignores the read/write bit
// - 10-bit high byte is 11110, A9, A8, zero; A9/A8 at bits 2 and 1
// - after high byte acknowledge, update flag sets and scl is held
// - low address byte compares all eight bits
// - after low byte, interrupt and update flag set and scl held, match or not
// - writing the slave address clears the update flag
// - 10-bit read only after a full write match and a restart
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defs.svh"

module i2cs_slave
	import i2cs_pkg::*;
#(
	parameter int DEPTH = `I2CS_BUF_DEPTH
)
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	output logic            scl_o,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_o,
	output logic            sda_oe_n,
	input  wire logic [3:0] port_mode_select,
	input  wire logic       address_hold_enable,
	input  wire logic       data_hold_enable,
	input  wire logic       ack_value_select,
	input  wire logic       hold_release,
	input  wire logic       addr_wr_stb,
	input  wire logic [7:0] addr_wr_data,
	input  wire logic [7:0] address_mask,
	input  wire logic       overflow_clr,
	input  wire logic       intr_clr,
	output logic [7:0]      slave_address_reg,
	output logic            ack_status_bit,
	output logic            ack_time_flag,
	output logic            update_address_flag,
	output logic            port_interrupt_flag,
	output logic            receive_overflow_flag,
	output logic            buffer_full_flag,
	output logic            read_request,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output i2cs_rx_t        rx_item
);

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic scl_meta_ff, scl_sync_ff, scl_dly_ff;
	logic sda_meta_ff, sda_sync_ff, sda_dly_ff;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_meta_ff <= 1'b1;
			scl_sync_ff <= 1'b1;
			scl_dly_ff  <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
			sda_dly_ff  <= 1'b1;
		end
		else
		begin
			scl_meta_ff <= scl_in;
			scl_sync_ff <= scl_meta_ff;
			scl_dly_ff  <= scl_sync_ff;
			sda_meta_ff <= sda_in;
			sda_sync_ff <= sda_meta_ff;
			sda_dly_ff  <= sda_sync_ff;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;

	assign scl_rise  = scl_sync_ff & ~scl_dly_ff;
	assign scl_fall  = ~scl_sync_ff & scl_dly_ff;
	assign start_det = scl_sync_ff & scl_dly_ff & sda_dly_ff & ~sda_sync_ff;
	assign stop_det  = scl_sync_ff & scl_dly_ff & ~sda_dly_ff & sda_sync_ff;

	// ****************************************
	// mode decode
	// ****************************************
	logic mode_en, mode_ten, mode_sp;

	assign mode_en  = (port_mode_select == `I2CS_MODE_7B) || (port_mode_select == `I2CS_MODE_10B)
		|| (port_mode_select == `I2CS_MODE_7B_SP) || (port_mode_select == `I2CS_MODE_10B_SP);
	assign mode_ten = port_mode_select[`I2CS_MODE_TEN_BIT];
	assign mode_sp  = port_mode_select[`I2CS_MODE_SP_BIT];

	// ****************************************
	// bit counter and shifter
	// ****************************************
	i2cs_state_t state_ff;
	i2cs_state_t nxt_state;
	logic [3:0]  bit_cnt_ff;
	logic [7:0]  shift_ff;
	logic [7:0]  addr_ff;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bit_cnt_ff <= '0;
			shift_ff   <= '0;
		end
		else if (start_det)
			bit_cnt_ff <= '0;
		else if (scl_rise && bit_cnt_ff != `I2CS_END_CNT)
		begin
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
			if (bit_cnt_ff != `I2CS_ACK_CNT)
				shift_ff <= {shift_ff[6:0], sda_sync_ff};
		end
		else if (scl_fall && bit_cnt_ff == `I2CS_END_CNT)
			bit_cnt_ff <= '0;
	end

	logic byte_done, ack_end, ack_sample;

	assign byte_done  = scl_fall && bit_cnt_ff == `I2CS_ACK_CNT && state_ff != ST_IDLE;
	assign ack_end    = scl_fall && bit_cnt_ff == `I2CS_END_CNT;
	assign ack_sample = scl_rise && bit_cnt_ff == `I2CS_ACK_CNT && state_ff != ST_IDLE;

	// ****************************************
	// address compare and byte decision
	// ****************************************
	logic [7:0] diff;
	logic       m7, m10h, mlo;
	logic       take, busy, ua_set, pif_evt, phase_hold, ten_ok_ff;

	assign diff = (shift_ff ^ addr_ff) & ~address_mask;
	assign m7   = (diff & `I2CS_RW_MASK) == '0;
	assign m10h = shift_ff[7:3] == `I2CS_TEN_PREFIX && diff[2:1] == 2'h0 && !shift_ff[0];
	assign mlo  = diff == '0;
	assign busy = buffer_full_flag | receive_overflow_flag;

	always_comb
	begin
		nxt_state  = state_ff;
		take       = 1'b0;
		ua_set     = 1'b0;
		pif_evt    = 1'b0;
		phase_hold = data_hold_enable;
		unique case (state_ff)
			ST_IDLE:
			begin
			end
			ST_ADDR:
			begin
				phase_hold = address_hold_enable;
				if (!mode_ten)
				begin
					take      = m7;
					nxt_state = !m7 ? ST_IDLE : (shift_ff[0] ? ST_READ : ST_DATA);
				end
				else if (m10h)
				begin
					take      = 1'b1;
					ua_set    = 1'b1;
					nxt_state = ST_ADDR_LO;
				end
				else if (ten_ok_ff && shift_ff[7:3] == `I2CS_TEN_PREFIX && diff[2:1] == 2'h0)
				begin
					take      = 1'b1;
					nxt_state = ST_READ;
				end
				else
					nxt_state = ST_IDLE;
			end
			ST_ADDR_LO:
			begin
				phase_hold = address_hold_enable;
				ua_set     = 1'b1;
				pif_evt    = 1'b1;
				take       = mlo;
				nxt_state  = mlo ? ST_DATA : ST_IDLE;
			end
			ST_DATA:
				take = 1'b1;
			ST_READ:
			begin
			end
		endcase
	end

	// ****************************************
	// state and 10-bit bookkeeping
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_ff <= ST_IDLE;
		else if (!mode_en || stop_det)
			state_ff <= ST_IDLE;
		else if (start_det)
			state_ff <= ST_ADDR;
		else if (byte_done)
			state_ff <= nxt_state;
	end

	// a read needs a prior full write match; stop forgets it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ten_ok_ff <= 1'b0;
		else if (stop_det || !mode_en)
			ten_ok_ff <= 1'b0;
		else if (byte_done && state_ff == ST_ADDR_LO)
			ten_ok_ff <= mlo;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			read_request <= 1'b0;
		else
			read_request <= (state_ff == ST_READ);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			addr_ff <= `I2CS_ADDR_RST;
		else if (addr_wr_stb)
			addr_ff <= addr_wr_data;
	end

	assign slave_address_reg = addr_ff;

	// ****************************************
	// acknowledge drive and status
	// ****************************************
	logic ack_ok_ff, hold_ff, ua_pend_ff, sw_ack;

	assign sw_ack = address_hold_enable | data_hold_enable;

	// ack decision is latched at the eighth fall so later buffer moves do not flip it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_ok_ff <= 1'b0;
		else if (byte_done)
			ack_ok_ff <= take & ~busy;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sda_oe_n <= 1'b1;
		else if (ack_end || start_det || stop_det)
			sda_oe_n <= 1'b1;
		else if (byte_done)
			sda_oe_n <= ~(take & ~busy & ~(sw_ack & phase_hold));
		else if (hold_ff && hold_release && ack_time_flag)
			sda_oe_n <= ~(ack_ok_ff & ~ack_value_select);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end
		else
		begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_status_bit <= 1'b0;
		else if (ack_sample)
			ack_status_bit <= sda_sync_ff;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ack_time_flag <= 1'b0;
		else if (byte_done && take && sw_ack)
			ack_time_flag <= 1'b1;
		else if (ack_end || stop_det)
			ack_time_flag <= 1'b0;
	end

	// ****************************************
	// clock stretching
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			hold_ff <= 1'b0;
		else if (byte_done && take && sw_ack && phase_hold)
			hold_ff <= 1'b1;
		else if (hold_release || stop_det)
			hold_ff <= 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ua_pend_ff <= 1'b0;
		else if (byte_done && ua_set)
			ua_pend_ff <= 1'b1;
		else if (ack_end)
			ua_pend_ff <= 1'b0;
	end

	// set after the acknowledge beats a software address write in the same cycle
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			update_address_flag <= 1'b0;
		else if (ack_end && ua_pend_ff)
			update_address_flag <= 1'b1;
		else if (addr_wr_stb)
			update_address_flag <= 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			scl_oe_n <= 1'b1;
		else
			scl_oe_n <= ~(hold_ff | update_address_flag);
	end

	// ****************************************
	// flags and receive buffer
	// ****************************************
	logic push;

	assign push = byte_done & take & ~busy;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			port_interrupt_flag <= 1'b0;
		else if (push || (byte_done && pif_evt) || (mode_en && mode_sp && (start_det || stop_det)))
			port_interrupt_flag <= 1'b1;
		else if (intr_clr)
			port_interrupt_flag <= 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			receive_overflow_flag <= 1'b0;
		else if (byte_done && take && busy)
			receive_overflow_flag <= 1'b1;
		else if (overflow_clr)
			receive_overflow_flag <= 1'b0;
	end

	logic     buf_in_ready;
	i2cs_rx_t buf_in;

	// one driver for the whole entry; address bytes carry the tag bit
	assign buf_in            = {state_ff != ST_DATA, shift_ff};
	assign buffer_full_flag  = ~buf_in_ready;

	i2cs_buf #(
		.W     ($bits(i2cs_rx_t)),
		.DEPTH (DEPTH)
	) u_buf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   (buf_in),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_item)
	);

	// ****************************************
	// checks
	// ****************************************
	a_ack_status_sample: assert property (@(posedge clk) disable iff (sys_rst)
		ack_sample |=> ack_status_bit == $past(sda_sync_ff))
		else $error("ack status not taken from bus");

	a_nack_when_busy: assert property (@(posedge clk) disable iff (sys_rst)
		byte_done && busy |=> sda_oe_n && receive_overflow_flag == $past(take | receive_overflow_flag))
		else $error("busy byte was acknowledged");

	a_auto_ack_drive: assert property (@(posedge clk) disable iff (sys_rst)
		byte_done && take && !busy && !sw_ack |=> !sda_oe_n throughout (!scl_fall [*2]))
		else $error("automatic acknowledge missing");

	a_ack_time_set: assert property (@(posedge clk) disable iff (sys_rst)
		byte_done && take && sw_ack |=> ack_time_flag)
		else $error("ack time flag not set");

	a_ack_time_gate: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(ack_time_flag) |-> $past(sw_ack) && $past(byte_done))
		else $error("ack time flag set without hold enable");

	a_ack_time_end: assert property (@(posedge clk) disable iff (sys_rst)
		ack_end |=> !ack_time_flag)
		else $error("ack time flag outlived ack pulse");

	a_mismatch_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		byte_done && state_ff == ST_ADDR && !take |=> state_ff == ST_IDLE && !$rose(port_interrupt_flag))
		else $error("mismatch left a trace");

	a_start_intr: assert property (@(posedge clk) disable iff (sys_rst)
		mode_en && mode_sp && start_det |=> port_interrupt_flag)
		else $error("start not flagged");

	a_ua_clear_wr: assert property (@(posedge clk) disable iff (sys_rst)
		addr_wr_stb && !(ack_end && ua_pend_ff) |=> !update_address_flag)
		else $error("address write left update flag set");

	a_ua_holds_scl: assert property (@(posedge clk) disable iff (sys_rst)
		update_address_flag && !addr_wr_stb |=> update_address_flag && !scl_oe_n)
		else $error("scl not held for address update");

	a_ten_prefix: assert property (@(posedge clk) disable iff (sys_rst)
		byte_done && state_ff == ST_ADDR && mode_ten && shift_ff[7:3] != `I2CS_TEN_PREFIX
		|=> state_ff == ST_IDLE)
		else $error("bad 10-bit prefix accepted");

endmodule

`default_nettype wire

// File: verification/i2cs_master_model.sv
/*
 * Behavioural i2c bus master for the slave block: start, stop, byte out.
 * Assumes the bench resolves scl and sda with pull-ups and feeds them back.
 */
`timescale 1ns/1ps
`default_nettype none

module i2cs_master_model
(
	input  wire logic clk,
	input  wire logic scl_w,
	input  wire logic sda_w,
	output logic      scl_m,
	output logic      sda_m
);
	// ****************************************
	// bus timing
	// ****************************************
	// low-phase step of the 125 ns bus period, in clk cycles
	localparam int Q = 6;

	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// slave may stretch; bounded so a stuck scl ends in the bench timeout
	task automatic rise_scl();
		int n;
		n = 0;
		scl_m <= 1'b1;
		do
			@(negedge clk);
		while (!scl_w && ++n < 4000);
		@(posedge clk);
		// high phase sized so one unstretched bit spans 25 clk
		tick(2 * Q - 1);
	endtask

	task automatic send_bit(input logic b, output logic s);
		sda_m <= b;
		tick(Q);
		rise_scl();
		@(negedge clk);
		s = sda_w;
		@(posedge clk);
		scl_m <= 1'b0;
		tick(Q);
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(d[i], s);
		send_bit(1'b1, ack);
	endtask

	// also serves as a repeated start from scl low
	task automatic start();
		sda_m <= 1'b1;
		tick(Q);
		rise_scl();
		sda_m <= 1'b0;
		tick(Q);
		scl_m <= 1'b0;
		tick(Q);
	endtask

	task automatic stop();
		sda_m <= 1'b0;
		tick(Q);
		rise_scl();
		sda_m <= 1'b1;
		tick(4 * Q);
	endtask
endmodule

`default_nettype wire

// File: verification/i2c_slave_ack_and_addressing_test.sv
/*
 * Self-checking bench of the i2c slave address and acknowledge engine.
 * Assumes rtl/ on the include path and the master model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defs.svh"

module i2c_slave_ack_and_addressing_test
	import i2cs_pkg::*;
;
	logic       clk, sys_rst, address_hold_enable, data_hold_enable, ack_value_select;
	logic       hold_release, addr_wr_stb, overflow_clr, intr_clr, rx_ready, stall, atf_seen, ack_st;
	logic [3:0] port_mode_select;
	logic [7:0] addr_wr_data, address_mask, a, mk, b, slave_address_reg;
	logic       scl_o, scl_oe_n, sda_o, sda_oe_n, scl_m, sda_m, hit, ack_status_bit, ack_time_flag;
	logic       update_address_flag, port_interrupt_flag, receive_overflow_flag, buffer_full_flag;
	logic       read_request, rx_valid;
	i2cs_rx_t   rx_item;
	logic [8:0] exp_q[$];
	int         bad_count, total_checks, cycles;
	logic [3:0] modes [4] = '{`I2CS_MODE_7B, `I2CS_MODE_10B, `I2CS_MODE_7B_SP, `I2CS_MODE_10B_SP};

	// ****************************************
	// wires with pull-ups, design and partner
	// ****************************************
	wire logic scl_w = scl_m & (scl_oe_n | scl_o);
	wire logic sda_w = sda_m & (sda_oe_n | sda_o);

	i2cs_master_model m (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));

	i2cs_slave dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_in(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .port_mode_select(port_mode_select),
		.address_hold_enable(address_hold_enable), .data_hold_enable(data_hold_enable),
		.ack_value_select(ack_value_select), .hold_release(hold_release), .addr_wr_stb(addr_wr_stb),
		.addr_wr_data(addr_wr_data), .address_mask(address_mask), .overflow_clr(overflow_clr),
		.intr_clr(intr_clr), .slave_address_reg(slave_address_reg), .ack_status_bit(ack_status_bit),
		.ack_time_flag(ack_time_flag), .update_address_flag(update_address_flag),
		.port_interrupt_flag(port_interrupt_flag), .receive_overflow_flag(receive_overflow_flag),
		.buffer_full_flag(buffer_full_flag), .read_request(read_request), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_item(rx_item));

	always #2.5 clk = ~clk;

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_vec(input string what, input logic [8:0] exp, input logic [8:0] got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// sampled on the falling edge so the pop edge has not landed yet
	always @(negedge clk)
		if (!sys_rst && rx_valid && rx_ready)
			chk_vec("rx_item", exp_q.size() ? exp_q.pop_front() : 9'h1FF, rx_item);

	always @(posedge clk)
	begin
		rx_ready <= !stall && $urandom_range(1);
		if (ack_time_flag)
			atf_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ****************************************
	// stimulus helpers
	// ****************************************
	task automatic write_addr(input logic [7:0] v);
		addr_wr_data <= v;
		addr_wr_stb  <= 1'b1;
		@(posedge clk);
		addr_wr_stb  <= 1'b0;
		@(posedge clk);
	endtask

	// 0 clears interrupt, 1 clears overflow, 2 releases a hold
	task automatic pulse(input int k);
		intr_clr     <= (k == 0);
		overflow_clr <= (k == 1);
		hold_release <= (k == 2);
		@(posedge clk);
		{intr_clr, overflow_clr, hold_release} <= 3'h0;
		@(posedge clk);
	endtask

	// nak is the expected sda level in the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic nak, input logic push, input logic isa);
		logic ack;
		if (push)
			exp_q.push_back({isa, d});
		// while stalled every byte is addressed; a silent mismatch keeps the old status
		if (push || stall)
			ack_st = nak;
		m.send_byte(d, ack);
		chk_bit("ack_level", nak, ack);
		chk_bit("ack_status", ack_st, ack_status_bit);
	endtask

	task automatic drain();
		stall <= 1'b0;
		@(posedge clk);
		for (int n = 0; n < 100 && rx_valid; n++)
			@(posedge clk);
	endtask

	// software acknowledge: wait for the hold, check it, then release it
	task automatic held_xfer(input logic [7:0] d, input logic nak, input logic isa);
		fork
			xfer(d, nak, 1'b1, isa);
			begin
				for (int n = 0; n < 2000 && !ack_time_flag; n++)
					@(posedge clk);
				repeat (2) @(posedge clk);
				chk_bit("ack_time", 1'b1, ack_time_flag);
				chk_bit("hold_scl", 1'b0, scl_oe_n);
				pulse(2);
			end
		join
		chk_bit("ack_time_end", 1'b0, ack_time_flag);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		{clk, address_hold_enable, data_hold_enable, ack_value_select, hold_release} = 5'h00;
		{addr_wr_stb, overflow_clr, intr_clr, rx_ready, stall, atf_seen, ack_st} = 7'h00;
		{addr_wr_data, address_mask, port_mode_select, cycles, bad_count, total_checks} = 0;
		sys_rst = 1'b1;
		void'($urandom(32'hC04A3EC2));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (modes[i])
		begin
			port_mode_select <= modes[i];
			pulse(0);
			m.start();
			chk_bit("start_int", modes[i][`I2CS_MODE_SP_BIT], port_interrupt_flag);
			pulse(0);
			m.stop();
			chk_bit("stop_int", modes[i][`I2CS_MODE_SP_BIT], port_interrupt_flag);
		end
		port_mode_select <= `I2CS_MODE_7B;
		repeat (12)
		begin
			a   = 8'($urandom);
			mk  = 8'($urandom) & 8'h16;
			b   = $urandom_range(1) ? a ^ (8'($urandom) & (mk | 8'h01)) : 8'($urandom);
			hit = ((b ^ a) & ~mk & 8'hFE) == 8'h00;
			address_mask <= mk;
			write_addr(a);
			chk_vec("addr_reg", {1'b0, a}, {1'b0, slave_address_reg});
			pulse(0);
			m.start();
			xfer(b, !hit, hit, 1'b1);
			chk_bit("addr_int", hit, port_interrupt_flag);
			if (hit && !b[0])
				xfer(8'($urandom), 1'b0, 1'b1, 1'b0);
			m.stop();
		end
		chk_bit("ack_time_idle", 1'b0, atf_seen);
		address_mask <= 8'h00;
		write_addr(8'h42);
		drain();
		stall <= 1'b1;
		m.start();
		xfer(8'h42, 1'b0, 1'b1, 1'b1);
		xfer(8'h3C, 1'b0, 1'b1, 1'b0);
		chk_bit("full", 1'b1, buffer_full_flag);
		xfer(8'hC3, 1'b1, 1'b0, 1'b0);
		chk_bit("overflow", 1'b1, receive_overflow_flag);
		m.stop();
		drain();
		chk_bit("full_drained", 1'b0, buffer_full_flag);
		pulse(1);
		chk_bit("overflow_clr", 1'b0, receive_overflow_flag);
		address_hold_enable <= 1'b1;
		for (int v = 1; v >= 0; v--)
		begin
			ack_value_select <= 1'(v);
			m.start();
			held_xfer(8'h42, 1'(v), 1'b1);
			m.stop();
		end
		address_hold_enable <= 1'b0;
		data_hold_enable    <= 1'b1;
		m.start();
		xfer(8'h42, 1'b0, 1'b1, 1'b1);
		held_xfer(8'h5A, 1'b0, 1'b0);
		m.stop();
		data_hold_enable <= 1'b0;
		port_mode_select <= `I2CS_MODE_10B;
		for (int j = 0; j < 2; j++)
		begin
			write_addr(8'hF2);
			m.start();
			xfer(8'hF2, 1'b0, 1'b1, 1'b1);
			chk_bit("ua_high", 1'b1, update_address_flag);
			chk_bit("hold_high", 1'b0, scl_oe_n);
			write_addr(8'h5C);
			chk_bit("ua_clr", 1'b0, update_address_flag);
			pulse(0);
			xfer(8'h5C + 8'(j == 0), 1'(j == 0), 1'(j), 1'b1);
			chk_bit("ua_low", 1'b1, update_address_flag);
			chk_bit("int_low", 1'b1, port_interrupt_flag);
			chk_bit("hold_low", 1'b0, scl_oe_n);
			write_addr(8'hF2);
			if (j == 1)
			begin
				m.start();
				xfer(8'hF3, 1'b0, 1'b1, 1'b1);
				chk_bit("read_req", 1'b1, read_request);
			end
			m.stop();
		end
		drain();
		chk_vec("left_items", 9'h000, 9'(exp_q.size()));
		end_sim();
	end
endmodule

`default_nettype wire
